//--- verilog/halt_wakeup_control.sv
// Halt mode selector, wake-up sequencer and auto-wake unit with AHB-Lite registers.
// Assumes hclk keeps running; oscillator and clock gates are driven as enables.
// Behaviour
// - Timer enables pick timer-kept halt, else ordinary
// - Reset wake from timer-kept halt waits startup
// - Interrupt wake from timer-kept halt resumes at once
// - Timer-kept halt entry clears interrupt mask
// - Timer-kept halt runs oscillator and timer only
// - Timer-kept halt suppresses watchdog halt reset
// - Auto-wake enable bit selects auto-wake halt
// - Wake delay is 4 startup plus 64 times prescaler RC edges
// - Expiry sets flag, restarts oscillator, services interrupt
// - Control register read clears flag, writes ignored
// - Measure bit routes RC to capture in run
// - Auto-wake halt stops oscillator and processing
// - Auto-wake halt entry clears interrupt mask
// - Option bit decides watchdog reset on halt
// - Prescaler value is the division factor, not zero
// - Zero prescaler wakes now or is ignored
// - Reset or halt-exit interrupt leaves auto-wake halt
// - Multiplier adds startup delay after oscillator delay
// - Ordinary halt stops oscillator when both disabled
`timescale 1ns/10ps
`default_nettype none

module halt_wakeup_control
    import halt_wake_pkg::*;
#(
    parameter bit zero_wakes_now = 1'b0
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [halt_wake_pkg::ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic halt_req,
    input wire logic wake_irq,
    input wire logic reset_wake,
    input wire logic watchdog_active,
    input wire logic watchdog_halt_option,
    input wire logic startup_long,
    input wire logic multiplier_option,
    input wire logic lite_timebase_irq_enable,
    input wire logic reload_overflow_irq_enable,
    input wire logic reload_clock_select_low,
    input wire logic reload_clock_select_high,
    input wire logic rc_clk,
    output logic osc_enable,
    output logic cpu_clk_enable,
    output logic periph_clk_enable,
    output logic timer_clk_enable,
    output logic main_clk_ready,
    output logic imask_clear,
    output logic irq_service,
    output logic reset_vector_fetch,
    output logic watchdog_reset,
    output logic rc_osc_enable,
    output logic rc_capture_out,
    output logic auto_wake_irq
);
    import halt_wake_pkg::*;

    state_t s;
    state_t n;
    logic acc;
    logic rc_rise;
    logic act_sel;
    logic wdg_hit;
    logic [12:0] startup;

    always_comb begin
        n = s;
        acc = hsel & hready & (htrans == HTRANS_NONSEQ);
        rc_rise = s.rc_s2 & ~s.rc_s3;
        act_sel = lite_timebase_irq_enable
            | (reload_overflow_irq_enable & ~reload_clock_select_high & reload_clock_select_low);
        wdg_hit = watchdog_active & watchdog_halt_option & (s.en | ~act_sel);
        startup = startup_long ? STARTUP_LONG : STARTUP_SHORT;

        n.rc_s1 = rc_clk;
        n.rc_s2 = s.rc_s1;
        n.rc_s3 = s.rc_s2;
        n.imask_clr = 1'b0;
        n.svc_irq = 1'b0;
        n.fetch_rst = 1'b0;
        n.wdg_rst = 1'b0;
        n.ready = 1'b1;
        n.resp = 1'b0;

        // Write data phase
        if (s.wr_pend) begin
            if (s.wr_addr == PRESC_ADDR) begin
                if (hwdata[7:0] != 8'h00 || zero_wakes_now) begin
                    n.presc = hwdata[7:0];
                end
            end else if (s.wr_addr == CSR_ADDR) begin
                n.en = hwdata[CSR_EN_BIT];
                n.meas = hwdata[CSR_MEAS_BIT];
            end
        end
        n.wr_pend = acc & hwrite;
        n.wr_addr = haddr;

        // Read data is captured in the address phase
        if (acc & ~hwrite) begin
            n.rdata = 32'h0000_0000;
            if (haddr == PRESC_ADDR) begin
                n.rdata[7:0] = s.presc;
            end else if (haddr == CSR_ADDR) begin
                n.rdata[2:0] = {s.flag, s.meas, s.en};
                n.flag = 1'b0;
            end
        end

        unique case (s.mode)
            ST_RUN: begin
                if (halt_req) begin
                    if (wdg_hit) begin
                        n.wdg_rst = 1'b1;
                    end else begin
                        n.imask_clr = 1'b1;
                        if (s.en) begin
                            n.mode = ST_AWU;
                            n.rcwait = 1'b1;
                            n.rcst = RC_STARTUP_EDGES;
                            n.fdiv = 6'h00;
                            n.pcnt = s.presc;
                        end else if (act_sel) begin
                            n.mode = ST_ACT;
                        end else begin
                            n.mode = ST_HALT;
                        end
                    end
                end
            end
            ST_ACT: begin
                if (reset_wake) begin
                    n.mode = ST_OSC;
                    n.wake_rst = 1'b1;
                    n.cnt = startup - 13'h0001;
                end else if (wake_irq) begin
                    n.mode = ST_RUN;
                    n.svc_irq = 1'b1;
                end
            end
            ST_HALT: begin
                if (reset_wake | wake_irq) begin
                    n.mode = ST_OSC;
                    n.wake_rst = reset_wake;
                    n.cnt = startup - 13'h0001;
                end
            end
            ST_AWU: begin
                if (reset_wake | wake_irq) begin
                    n.mode = ST_OSC;
                    n.wake_rst = reset_wake;
                    n.cnt = startup - 13'h0001;
                end else if (s.pcnt == 8'h00) begin
                    n.flag = 1'b1;
                    n.mode = ST_OSC;
                    n.wake_rst = 1'b0;
                    n.cnt = startup - 13'h0001;
                end else if (rc_rise) begin
                    if (s.rcwait) begin
                        if (s.rcst <= 8'h01) begin
                            n.rcwait = 1'b0;
                        end else begin
                            n.rcst = s.rcst - 8'h01;
                        end
                    end else if (s.fdiv == FIX_DIV_LAST && s.pcnt == 8'h01) begin
                        n.flag = 1'b1;
                        n.mode = ST_OSC;
                        n.wake_rst = 1'b0;
                        n.cnt = startup - 13'h0001;
                    end else begin
                        n.fdiv = s.fdiv + 6'h01;
                        if (s.fdiv == FIX_DIV_LAST) begin
                            n.pcnt = s.pcnt - 8'h01;
                        end
                    end
                end
            end
            ST_OSC: begin
                if (s.cnt != 13'h0000) begin
                    n.cnt = s.cnt - 13'h0001;
                end else if (multiplier_option) begin
                    n.mode = ST_PLL;
                    n.cnt = PLL_STARTUP_CYC - 13'h0001;
                end else begin
                    n.mode = ST_RUN;
                    n.fetch_rst = s.wake_rst;
                    n.svc_irq = ~s.wake_rst;
                end
            end
            ST_PLL: begin
                if (s.cnt != 13'h0000) begin
                    n.cnt = s.cnt - 13'h0001;
                end else begin
                    n.mode = ST_RUN;
                    n.fetch_rst = s.wake_rst;
                    n.svc_irq = ~s.wake_rst;
                end
            end
            default: begin
                n.mode = ST_RUN;
            end
        endcase

        // Clock gates follow the next mode
        n.osc_en = (n.mode != ST_HALT) && (n.mode != ST_AWU);
        n.cpu_en = (n.mode == ST_RUN);
        n.periph_en = (n.mode == ST_RUN);
        n.timer_en = (n.mode == ST_RUN) || (n.mode == ST_ACT);
        n.clk_ok = (n.mode == ST_RUN);
        n.rc_en = (n.mode == ST_AWU) || (n.meas && n.mode == ST_RUN);
        n.rc_cap = s.rc_s2 & n.meas & (n.mode == ST_RUN);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
            s.presc <= PRESC_RST;
            {s.flag, s.meas, s.en} <= CSR_RST[2:0];
            s.ready <= 1'b1;
            s.osc_en <= 1'b1;
            s.cpu_en <= 1'b1;
            s.periph_en <= 1'b1;
            s.timer_en <= 1'b1;
            s.clk_ok <= 1'b1;
        end else if (clk_en) begin
            s <= n;
        end
    end

    assign hrdata = s.rdata;
    assign hreadyout = s.ready;
    assign hresp = s.resp;
    assign osc_enable = s.osc_en;
    assign cpu_clk_enable = s.cpu_en;
    assign periph_clk_enable = s.periph_en;
    assign timer_clk_enable = s.timer_en;
    assign main_clk_ready = s.clk_ok;
    assign imask_clear = s.imask_clr;
    assign irq_service = s.svc_irq;
    assign reset_vector_fetch = s.fetch_rst;
    assign watchdog_reset = s.wdg_rst;
    assign rc_osc_enable = s.rc_en;
    assign rc_capture_out = s.rc_cap;
    assign auto_wake_irq = s.flag;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn || !clk_en);

    halt_select_a: assert property (
        s.mode == ST_RUN && halt_req && !s.en && act_sel && !wdg_hit |=> s.mode == ST_ACT
    ) else $error("timer-kept halt not selected");

    plain_halt_a: assert property (
        s.mode == ST_RUN && halt_req && !s.en && !act_sel && !wdg_hit
        |=> s.mode == ST_HALT && !osc_enable
    ) else $error("ordinary halt not entered with oscillator off");

    mask_clear_a: assert property (
        s.mode == ST_RUN && halt_req && !s.en && act_sel && !wdg_hit |=> imask_clear && s.mode == ST_ACT
    ) else $error("timer-kept halt entry kept interrupt mask");

    entry_mask_a: assert property (
        $rose(s.mode == ST_AWU || s.mode == ST_ACT || s.mode == ST_HALT)
        |-> imask_clear && !cpu_clk_enable
    ) else $error("halt entry without mask clear");

    act_irq_a: assert property (
        s.mode == ST_ACT && !reset_wake && wake_irq |=> s.mode == ST_RUN && irq_service && cpu_clk_enable
    ) else $error("interrupt wake from timer-kept halt not immediate");

    startup_load_a: assert property (
        s.mode != ST_OSC ##1 s.mode == ST_OSC
        |-> s.cnt == (startup_long ? 13'h0fff : 13'h00ff)
    ) else $error("startup delay loaded wrong");

    startup_end_a: assert property (
        s.mode == ST_OSC && s.cnt == 13'h0000 && !multiplier_option
        |=> s.mode == ST_RUN && (reset_vector_fetch ^ irq_service)
    ) else $error("startup delay end not serviced");

    act_clocks_a: assert property (
        s.mode == ST_ACT |-> osc_enable && timer_clk_enable && !periph_clk_enable
    ) else $error("timer-kept halt clock gating wrong");

    awu_clocks_a: assert property (
        s.mode == ST_AWU |-> !osc_enable && !cpu_clk_enable && !timer_clk_enable && rc_osc_enable
    ) else $error("auto-wake halt clock gating wrong");

    act_watchdog_a: assert property (
        s.mode == ST_RUN && halt_req && !s.en && act_sel |=> !watchdog_reset
    ) else $error("watchdog reset in timer-kept halt");

    awu_watchdog_a: assert property (
        s.mode == ST_RUN && halt_req && s.en && watchdog_active && watchdog_halt_option
        |=> watchdog_reset && s.mode == ST_RUN
    ) else $error("watchdog halt option ignored");

    flag_read_a: assert property (
        acc && !hwrite && haddr == CSR_ADDR && s.mode != ST_AWU
        |=> !auto_wake_irq && hrdata[CSR_FLAG_BIT] == $past(s.flag)
    ) else $error("flag not cleared by read");

    flag_write_a: assert property (
        s.wr_pend && s.wr_addr == CSR_ADDR && !acc && s.mode != ST_AWU
        |=> auto_wake_irq == $past(auto_wake_irq)
    ) else $error("flag changed by write");

    measure_route_a: assert property (
        s.meas && s.mode == ST_RUN && !halt_req && !s.wr_pend |=> rc_osc_enable
    ) else $error("measure mode not routing RC");

    awu_wake_a: assert property (
        s.mode == ST_AWU && (reset_wake || wake_irq) |=> s.mode == ST_OSC && osc_enable
    ) else $error("auto-wake halt exit failed");

    pll_wait_a: assert property (
        s.mode == ST_OSC && s.cnt == 13'h0000 && multiplier_option
        |=> s.mode == ST_PLL && !main_clk_ready
    ) else $error("multiplier startup skipped");

    reserved_a: assert property (
        $past(acc && !hwrite && haddr == CSR_ADDR) |-> hrdata[31:3] == 29'h0
    ) else $error("reserved bits not zero");

    prescale_step_a: assert property (
        s.mode == ST_AWU && rc_rise && !s.rcwait && s.fdiv == FIX_DIV_LAST && s.pcnt > 8'h01
        && !reset_wake && !wake_irq |=> s.pcnt == $past(s.pcnt) - 8'h01 && s.fdiv == 6'h00
    ) else $error("prescaler step wrong");

    awu_enter_a: assert property (
        s.mode == ST_RUN && halt_req && s.en && !wdg_hit |=> s.mode == ST_AWU && rc_osc_enable && imask_clear
    ) else $error("auto-wake halt not entered");

    awu_expire_a: assert property (
        s.mode == ST_AWU && rc_rise && !s.rcwait && s.fdiv == FIX_DIV_LAST && s.pcnt == 8'h01
        && !reset_wake && !wake_irq |=> s.mode == ST_OSC && auto_wake_irq && osc_enable
    ) else $error("auto-wake expiry did not wake");

    flag_hold_a: assert property (
        auto_wake_irq && !(acc && !hwrite && haddr == CSR_ADDR) |=> auto_wake_irq
    ) else $error("wake flag lost without read");

    presc_nonzero_a: assert property (
        zero_wakes_now || s.presc != 8'h00
    ) else $error("zero prescaler accepted");

    reset_fetch_a: assert property (
        s.mode == ST_OSC && s.cnt == 13'h0000 && s.wake_rst && !multiplier_option
        |=> reset_vector_fetch && !irq_service
    ) else $error("reset wake did not fetch vector");

    pll_done_a: assert property (
        s.mode == ST_PLL && s.cnt == 13'h0000 |=> s.mode == ST_RUN && main_clk_ready
    ) else $error("clock not delivered after multiplier delay");

    capture_idle_a: assert property (
        s.mode != ST_RUN |-> !rc_capture_out
    ) else $error("capture routed outside run");

endmodule

`default_nettype wire

//--- verilog/halt_wake_pkg.sv
// Constants and state types for the halt and auto-wake controller.
// Assumes a 40 MHz hclk and a 12-bit AHB-Lite byte address.
package halt_wake_pkg;

    localparam int unsigned ADDR_W = 12;

    // Register indexes, byte address is four times the index
    localparam logic [ADDR_W-1:0] PRESC_IDX = 12'h049;
    localparam logic [ADDR_W-1:0] CSR_IDX = 12'h04a;
    localparam logic [ADDR_W-1:0] PRESC_ADDR = {PRESC_IDX[ADDR_W-3:0], 2'b00};
    localparam logic [ADDR_W-1:0] CSR_ADDR = {CSR_IDX[ADDR_W-3:0], 2'b00};

    localparam logic [7:0] PRESC_RST = 8'hff;
    localparam logic [7:0] CSR_RST = 8'h00;
    localparam int unsigned CSR_EN_BIT = 0;
    localparam int unsigned CSR_MEAS_BIT = 1;
    localparam int unsigned CSR_FLAG_BIT = 2;

    // Fixed divider of 64 as a 6-bit wrap counter
    localparam logic [5:0] FIX_DIV_LAST = 6'h3f;
    localparam logic [7:0] RC_STARTUP_EDGES = 8'h04;

    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam logic [12:0] STARTUP_SHORT = 13'h0100;
    localparam logic [12:0] STARTUP_LONG = 13'h1000;
    localparam int unsigned PLL_STARTUP_NS = 50000;
    localparam int unsigned PLL_STARTUP_CYC_I = (PLL_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [12:0] PLL_STARTUP_CYC = PLL_STARTUP_CYC_I[12:0];

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_ACT = 3'b001,
        ST_HALT = 3'b010,
        ST_AWU = 3'b011,
        ST_OSC = 3'b100,
        ST_PLL = 3'b101
    } mode_t;

    typedef struct packed {
        mode_t mode;
        logic wake_rst;
        logic [12:0] cnt;
        logic [5:0] fdiv;
        logic [7:0] pcnt;
        logic [7:0] rcst;
        logic rcwait;
        logic [7:0] presc;
        logic en;
        logic meas;
        logic flag;
        logic rc_s1;
        logic rc_s2;
        logic rc_s3;
        logic wr_pend;
        logic [ADDR_W-1:0] wr_addr;
        logic [31:0] rdata;
        logic ready;
        logic resp;
        logic osc_en;
        logic cpu_en;
        logic periph_en;
        logic timer_en;
        logic clk_ok;
        logic imask_clr;
        logic svc_irq;
        logic fetch_rst;
        logic wdg_rst;
        logic rc_en;
        logic rc_cap;
    } state_t;

endpackage

//--- sim/rc_osc_model.sv
// Auto-wake RC oscillator standing at the controller's rc_clk pin.
// Assumes its enable is the controller's rc_osc_enable output.
`timescale 1ns/10ps
`default_nettype none

module rc_osc_model #(
    parameter int half_ns = 61
) (
    input wire logic enable,
    output logic rc_clk
);
    initial rc_clk = 1'b0;

    // Runs only while enabled, stands still low otherwise
    always begin
        wait (enable === 1'b1);
        #(half_ns) rc_clk = enable ? ~rc_clk : 1'b0;
    end
endmodule

`default_nettype wire

//--- sim/halt_wakeup_control_test.sv
// Self-checking bench for the halt and auto-wake controller.
// Assumes rc_osc_model as the RC source and one 40 MHz clock.
`timescale 1ns/10ps
`default_nettype none

module halt_wakeup_control_test;
    import halt_wake_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [3:0] tmr = 4'h0;
    logic halt_req = 1'b0;
    logic wake_irq = 1'b0;
    logic reset_wake = 1'b0;
    logic wdg_on = 1'b0;
    logic wdg_opt = 1'b0;
    logic slow_start = 1'b0;
    logic mult = 1'b0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, osc_enable, cpu_clk_enable, periph_clk_enable, timer_clk_enable;
    logic main_clk_ready, imask_clear, irq_service, reset_vector_fetch, watchdog_reset;
    logic rc_osc_enable, rc_capture_out, auto_wake_irq, rc_clk;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    wire logic [5:0] evt;
    wire logic [31:0] gates;
    // Event index: 0 mask clear, 1 service, 2 vector fetch, 3 wake flag, 4 watchdog, 5 capture
    assign evt = {rc_capture_out, watchdog_reset, auto_wake_irq, reset_vector_fetch, irq_service, imask_clear};
    assign gates = {28'h0, osc_enable, cpu_clk_enable, periph_clk_enable, timer_clk_enable};

    always #12.5 hclk = ~hclk;

    halt_wakeup_control halt_wakeup_control_inst (
        .hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .halt_req(halt_req),
        .wake_irq(wake_irq), .reset_wake(reset_wake), .watchdog_active(wdg_on),
        .watchdog_halt_option(wdg_opt), .startup_long(slow_start), .multiplier_option(mult),
        .lite_timebase_irq_enable(tmr[3]), .reload_overflow_irq_enable(tmr[2]),
        .reload_clock_select_high(tmr[1]), .reload_clock_select_low(tmr[0]), .rc_clk(rc_clk),
        .osc_enable(osc_enable), .cpu_clk_enable(cpu_clk_enable),
        .periph_clk_enable(periph_clk_enable), .timer_clk_enable(timer_clk_enable),
        .main_clk_ready(main_clk_ready), .imask_clear(imask_clear), .irq_service(irq_service),
        .reset_vector_fetch(reset_vector_fetch), .watchdog_reset(watchdog_reset),
        .rc_osc_enable(rc_osc_enable), .rc_capture_out(rc_capture_out), .auto_wake_irq(auto_wake_irq)
    );

    rc_osc_model rc_osc_model_inst (.enable(rc_osc_enable), .rc_clk(rc_clk));

    task automatic final_report;
        $display("Comparisons %0d, errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            final_report;
        end
    end

    task automatic check(input logic [31:0] act, input logic [31:0] exp);
        comparisons++;
        if (act !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, act, exp);
        end
    endtask

    task automatic rng(input int n, input int lo, input int hi);
        comparisons++;
        if (n < lo || n > hi) begin
            num_errors++;
            $display("Error at %0t: got %h cycles expected %h to %h", $time, n, lo, hi);
        end
    endtask

    // One single transfer, entered and left at a rising edge
    task automatic ahb(input logic [11:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] t;
        ahb(a, 1'b1, d, t);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] t;
        ahb(a, 1'b0, 32'h0000_0000, t);
        check(t, e);
    endtask

    task automatic wait_evt(input int idx, input int lim, output int n);
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (evt[idx] !== 1'b1 && n < lim);
    endtask

    // Halt pulse, then the answer pulse and the gate levels beside it
    task automatic halt_entry(input int idx, input logic [3:0] g);
        int n;
        halt_req <= 1'b1;
        @(posedge hclk);
        halt_req <= 1'b0;
        wait_evt(idx, 4, n);
        rng(n, 1, 3);
        check(gates, {28'h0, g});
        check({31'h0, main_clk_ready}, {31'h0, g[2]});
    endtask

    task automatic wake(input int lo, input int hi);
        int n;
        wake_irq <= 1'b1;
        wait_evt(1, hi + 2, n);
        wake_irq <= 1'b0;
        rng(n, lo, hi);
        check(gates, 32'h0000_000f);
    endtask

    task automatic t_regs;
        check({31'h0, hresp}, 32'h0000_0000);
        rd_chk(PRESC_ADDR, 32'h0000_00ff);
        rd_chk(CSR_ADDR, 32'h0000_0000);
        wr(CSR_ADDR, 32'h0000_00fc);
        rd_chk(CSR_ADDR, 32'h0000_0000);
        rd_chk(12'h000, 32'h0000_0000);
        wr(PRESC_ADDR, 32'h0000_0000);
        rd_chk(PRESC_ADDR, 32'h0000_00ff);
    endtask

    task automatic t_modes;
        logic [3:0] cfg [4] = '{4'b1000, 4'b0101, 4'b0111, 4'b0100};
        for (int i = 0; i < 4; i++) begin
            tmr <= cfg[i];
            if (i < 2) begin
                halt_entry(0, 4'b1001);
                wake(1, 2);
            end else begin
                halt_entry(0, 4'b0000);
                wake(250, 262);
            end
        end
    endtask

    task automatic t_reset_wake;
        int n;
        tmr <= 4'b1000;
        halt_entry(0, 4'b1001);
        reset_wake <= 1'b1;
        wait_evt(2, 270, n);
        reset_wake <= 1'b0;
        rng(n, 250, 262);
    endtask

    task automatic t_wdg;
        wdg_on <= 1'b1;
        wdg_opt <= 1'b1;
        halt_entry(0, 4'b1001);
        wake(1, 2);
        tmr <= 4'b0000;
        halt_entry(4, 4'b1111);
        wdg_opt <= 1'b0;
        halt_entry(0, 4'b0000);
        wake(250, 262);
        wdg_on <= 1'b0;
    endtask

    task automatic t_awu;
        int n;
        wr(PRESC_ADDR, 32'h0000_0002);
        rd_chk(PRESC_ADDR, 32'h0000_0002);
        wr(CSR_ADDR, 32'h0000_0001);
        slow_start <= 1'b1;
        mult <= 1'b1;
        tmr <= 4'b1000;
        halt_entry(0, 4'b0000);
        check({31'h0, rc_osc_enable}, 32'h0000_0001);
        // 4 startup plus 128 RC rises of 122 ns
        wait_evt(3, 700, n);
        rng(n, 630, 660);
        wait_evt(1, 6200, n);
        rng(n, 6088, 6105);
        check(gates, 32'h0000_000f);
        wr(CSR_ADDR, 32'h0000_0001);
        rd_chk(CSR_ADDR, 32'h0000_0005);
        rd_chk(CSR_ADDR, 32'h0000_0001);
        check({31'h0, auto_wake_irq}, 32'h0000_0000);
        slow_start <= 1'b0;
        mult <= 1'b0;
        halt_entry(0, 4'b0000);
        wake(250, 262);
        wr(CSR_ADDR, 32'h0000_0000);
        tmr <= 4'b0000;
    endtask

    task automatic t_meas;
        int n;
        wr(CSR_ADDR, 32'h0000_0002);
        wait_evt(5, 20, n);
        rng(n, 1, 19);
        check({31'h0, rc_osc_enable}, 32'h0000_0001);
        wr(CSR_ADDR, 32'h0000_0000);
        repeat (2) @(posedge hclk);
        check({31'h0, rc_osc_enable}, 32'h0000_0000);
    endtask

    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs;
        t_modes;
        t_reset_wake;
        t_wdg;
        t_awu;
        t_meas;
        final_report;
    end
endmodule

`default_nettype wire
